/* File: inc/lcdhp_pkg.sv */
// lcdhp_pkg: constants and carrier types of the host port and pixel memory block.
// assumes: included ahead of every design file; nothing is imported, names are scoped.
package lcdhp_pkg;

  // ==========================================================
  // index numbers of the control registers
  localparam logic [4:0] IDX_OSC_START = 5'h00;
  localparam logic [4:0] IDX_DRIVER_OUT = 5'h01;
  localparam logic [4:0] IDX_POWER = 5'h03;
  localparam logic [4:0] IDX_ENTRY = 5'h05;
  localparam logic [4:0] IDX_BITOP = 5'h06;
  localparam logic [4:0] IDX_DISPLAY = 5'h07;
  localparam logic [4:0] IDX_WRITE_MASK = 5'h10;
  localparam logic [4:0] IDX_ADDR_SET = 5'h11;
  localparam logic [4:0] IDX_PIXEL_DATA = 5'h12;
  localparam logic [4:0] IDX_MAX = 5'h12;

  // ==========================================================
  // field positions
  localparam int DRV_LINES_LSB = 0;
  localparam int DRV_COL_ORDER_BIT = 8;
  localparam int DRV_ROW_ORDER_BIT = 9;
  localparam int PWR_STANDBY_BIT = 0;
  localparam int PWR_SLEEP_BIT = 1;
  localparam int ENT_STEP_DOWN_BIT = 0;
  localparam int ENT_READ_ADVANCE_BIT = 1;
  localparam int ENT_MID_GRAY_BIT = 2;
  localparam int BOP_ROT_LSB = 0;
  localparam int BOP_OP_LSB = 4;
  localparam int DSP_ON_BIT = 0;

  // ==========================================================
  // values after reset
  localparam logic [15:0] RST_DRIVER_OUT = 16'h000F;
  localparam logic [15:0] RST_POWER = 16'h0000;
  localparam logic [15:0] RST_ENTRY = 16'h0000;
  localparam logic [15:0] RST_BITOP = 16'h0000;
  localparam logic [15:0] RST_DISPLAY = 16'h0000;
  localparam logic [15:0] RST_WRITE_MASK = 16'h0000;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [4:0] RST_INDEX = 5'h00;
  localparam logic [10:0] RST_POINTER = 11'h000;

  // ==========================================================
  // interface mode pin codes and counts
  localparam logic [2:0] MODE_68_16 = 3'h0;
  localparam logic [2:0] MODE_68_8 = 3'h1;
  localparam logic [2:0] MODE_80_16 = 3'h2;
  localparam logic [2:0] MODE_80_8 = 3'h3;
  localparam int MODE_SERIAL_BIT = 2;
  localparam logic [4:0] SER_START_LAST = 5'h07;
  localparam logic [4:0] SER_FRAME_LAST = 5'h17;
  localparam logic [2:0] FRC_FRAMES = 3'h6;
  localparam logic [2:0] FRC_THIRD = 3'h3;
  localparam int WORDS_PER_ROW = 16;

  // ==========================================================
  // carrier types
  typedef enum logic [1:0] {LCDHP_ACC_INDEX, LCDHP_ACC_WRITE, LCDHP_ACC_READ} lcdhp_acc_e;
  typedef enum logic [1:0] {LCDHP_OP_REPLACE, LCDHP_OP_OR, LCDHP_OP_AND, LCDHP_OP_XOR} lcdhp_op_e;

  typedef struct packed {
    lcdhp_acc_e kind;
    logic [15:0] data;
  } lcdhp_acc_s;

endpackage

/* File: src/lcdhp_fifo.sv */
// lcdhp_fifo: synchronous FIFO with valid/ready on both sides.
// assumes: one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module lcdhp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("lcdhp_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;
  logic push;
  logic pop;

  assign o_in_ready = (wr_ptr_q ^ rd_ptr_q) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wr_ptr_q != rd_ptr_q;
  assign o_out_data = store_q[rd_ptr_q[AW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_core_clk) begin
    if (push) begin
      store_q[wr_ptr_q[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end
endmodule // lcdhp_fifo
`default_nettype wire

/* File: src/lcdhp_host_port.sv */
// lcdhp_host_port: host bus port, pixel memory, write path and display refresh.
// assumes: host pins are asynchronous and pass a 3-stage filter; one core clock.
`timescale 1ns/1ps
`default_nettype none
module lcdhp_host_port #(
  parameter int FIFO_DEPTH = 16,
  parameter int LINE_CYCLES = 64
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [2:0] i_interface_mode_pins,
  input wire logic i_chip_select_n,
  input wire logic i_command_data_select,
  input wire logic i_write_strobe_clk,
  input wire logic i_read_strobe_dir,
  input wire logic [15:0] i_host_data_bus,
  output logic [15:0] o_host_data_bus,
  output logic o_host_data_oe_n,
  output logic o_host_wait,
  output logic [127:0] o_row_drive_outputs,
  output logic [127:0] o_column_drive_outputs,
  output logic o_drive_blank
);
  localparam int CW = $clog2(LINE_CYCLES);
  localparam int PW = 23;
  localparam int AW = $bits(lcdhp_pkg::lcdhp_acc_s);

  generate
    if (LINE_CYCLES < 20 || LINE_CYCLES > 4096 || FIFO_DEPTH < 2) begin : g_bad_param
      $error("lcdhp_host_port needs 20..4096 line cycles and a fifo of 2 or more");
    end
  endgenerate

  // ==========================================================
  // functions
  function automatic logic pixel_on(input logic [1:0] code, input logic [2:0] frame,
                                    input logic half);
    logic [2:0] third;
    third = (frame >= lcdhp_pkg::FRC_THIRD) ? frame - lcdhp_pkg::FRC_THIRD : frame;
    unique case (code)
      2'b00: pixel_on = 1'b0;
      2'b01: pixel_on = half ? !frame[0] : (third == 3'h0);
      2'b10: pixel_on = (third != 3'h2);
      2'b11: pixel_on = 1'b1;
    endcase
  endfunction

  function automatic logic [6:0] column_of(input logic [3:0] word, input logic [2:0] pix,
                                           input logic reverse);
    column_of = reverse ? ~{word, pix} : {word, pix};
  endfunction

  function automatic logic [15:0] merge_word(input logic [15:0] host, input logic [3:0] rot,
                                             input logic [1:0] op, input logic [15:0] staged,
                                             input logic [15:0] old, input logic [15:0] mask);
    logic [15:0] turned;
    logic [15:0] combined;
    turned = 16'((({host, host} << rot) >> 16));
    unique case (lcdhp_pkg::lcdhp_op_e'(op))
      lcdhp_pkg::LCDHP_OP_REPLACE: combined = turned;
      lcdhp_pkg::LCDHP_OP_OR: combined = turned | staged;
      lcdhp_pkg::LCDHP_OP_AND: combined = turned & staged;
      lcdhp_pkg::LCDHP_OP_XOR: combined = turned ^ staged;
    endcase
    merge_word = (combined & ~mask) | (old & mask);
  endfunction

  // ==========================================================
  // pin filter: three stages, a change counts when stages two and three agree
  logic [PW-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q, pin_prev_q;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      pin_s3_q <= '1;
      pin_q <= '1;
      pin_prev_q <= '1;
    end else begin
      pin_s1_q <= {i_interface_mode_pins, i_chip_select_n, i_command_data_select,
                   i_write_strobe_clk, i_read_strobe_dir, i_host_data_bus};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
      pin_prev_q <= pin_q;
    end
  end

  logic [2:0] mode;
  logic cds, strb, strb_prev, dir, dir_prev, sel;
  logic [15:0] bus_in;
  assign mode = pin_q[22:20];
  assign sel = !pin_q[19] && !pin_prev_q[19];
  assign cds = pin_q[18];
  assign strb = pin_q[17];
  assign strb_prev = pin_prev_q[17];
  assign dir = pin_q[16];
  assign dir_prev = pin_prev_q[16];
  assign bus_in = pin_q[15:0];

  // ==========================================================
  // access decode per interface mode
  logic serial, is68, narrow;
  logic par_end, par_read, rd_start, rd_level;
  assign serial = mode[lcdhp_pkg::MODE_SERIAL_BIT];
  assign is68 = (mode == lcdhp_pkg::MODE_68_16) || (mode == lcdhp_pkg::MODE_68_8);
  assign narrow = (mode == lcdhp_pkg::MODE_68_8) || (mode == lcdhp_pkg::MODE_80_8);

  always_comb begin
    if (is68) begin
      par_end = sel && !strb && strb_prev;
      par_read = dir_prev;
      rd_start = sel && strb && !strb_prev && dir;
      rd_level = sel && strb && dir;
    end else begin
      par_end = sel && ((strb && !strb_prev) || (dir && !dir_prev));
      par_read = dir && !dir_prev;
      rd_start = sel && !dir && dir_prev;
      rd_level = sel && !dir;
    end
  end

  logic [15:0] read_staging_word_q;
  logic byte_low_q;
  logic [7:0] byte_hi_q;
  logic [4:0] ser_cnt_q;
  logic ser_rs_q, ser_rw_q;
  logic [15:0] ser_sh_q;
  logic scl_rise, scl_fall, ser_end;

  assign scl_rise = serial && sel && strb && !strb_prev;
  assign scl_fall = serial && sel && !strb && strb_prev;
  assign ser_end = scl_rise && (ser_cnt_q == lcdhp_pkg::SER_FRAME_LAST);

  // 8-bit modes pair two transfers, upper byte first
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      byte_low_q <= 1'b0;
      byte_hi_q <= 8'h00;
    end else if (!serial && narrow && par_end && (cds || !par_read)) begin
      byte_low_q <= !byte_low_q;
      byte_hi_q <= bus_in[7:0];
    end
  end

  // serial frame: start byte ending in select and direction, then 16 data bits
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ser_cnt_q <= 5'h00;
      ser_rs_q <= 1'b0;
      ser_rw_q <= 1'b0;
      ser_sh_q <= lcdhp_pkg::RST_WORD;
    end else if (!sel) begin
      ser_cnt_q <= 5'h00;
    end else if (scl_rise) begin
      ser_sh_q <= {ser_sh_q[14:0], dir};
      ser_cnt_q <= ser_end ? 5'h00 : ser_cnt_q + 5'h01;
      if (ser_cnt_q == lcdhp_pkg::SER_START_LAST) begin
        ser_rs_q <= ser_sh_q[0];
        ser_rw_q <= dir;
      end
    end
  end

  // ==========================================================
  // access queue toward the internal sequencer
  lcdhp_pkg::lcdhp_acc_s push_acc, pop_acc;
  logic push_valid, fifo_ready, pop_valid, pop_ready;

  always_comb begin
    push_valid = 1'b0;
    push_acc.kind = lcdhp_pkg::LCDHP_ACC_INDEX;
    push_acc.data = bus_in;
    if (serial) begin
      push_acc.data = {ser_sh_q[14:0], dir};
      push_acc.kind = !ser_rs_q ? lcdhp_pkg::LCDHP_ACC_INDEX
                    : ser_rw_q ? lcdhp_pkg::LCDHP_ACC_READ : lcdhp_pkg::LCDHP_ACC_WRITE;
      push_valid = ser_end && !(ser_rw_q && !ser_rs_q);
    end else begin
      if (narrow) begin
        push_acc.data = {byte_hi_q, bus_in[7:0]};
      end
      push_acc.kind = !cds ? lcdhp_pkg::LCDHP_ACC_INDEX
                    : par_read ? lcdhp_pkg::LCDHP_ACC_READ
                    : lcdhp_pkg::LCDHP_ACC_WRITE;
      push_valid = par_end && (cds || !par_read) && (!narrow || byte_low_q);
    end
  end

  lcdhp_fifo #(
    .WIDTH(AW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_in_valid(push_valid),
    .o_in_ready(fifo_ready),
    .i_in_data(push_acc),
    .o_out_valid(pop_valid),
    .i_out_ready(pop_ready),
    .o_out_data(pop_acc)
  );

  // ==========================================================
  // host bus answer
  logic [15:0] host_data_q;
  logic host_oe_n_q, host_wait_q;
  logic [3:0] ser_bit;
  assign ser_bit = 4'(lcdhp_pkg::SER_FRAME_LAST - ser_cnt_q);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      host_data_q <= lcdhp_pkg::RST_WORD;
      host_oe_n_q <= 1'b1;
      host_wait_q <= 1'b0;
    end else begin
      host_wait_q <= !fifo_ready;
      if (serial) begin
        host_oe_n_q <= !(sel && ser_rs_q && ser_rw_q && ser_cnt_q > lcdhp_pkg::SER_START_LAST);
        if (scl_fall) begin
          host_data_q <= {15'h0000, read_staging_word_q[ser_bit]};
        end
      end else begin
        host_oe_n_q <= !(rd_level && cds);
        if (rd_start && cds) begin
          host_data_q <= !narrow ? read_staging_word_q
                       : byte_low_q ? {8'h00, read_staging_word_q[7:0]}
                       : {8'h00, read_staging_word_q[15:8]};
        end
      end
    end
  end

  // ==========================================================
  // internal sequencer and control registers
  typedef enum logic {LCDHP_SEQ_IDLE, LCDHP_SEQ_MERGE} lcdhp_seq_e;
  lcdhp_seq_e seq_q;
  logic [4:0] index_select_q;
  logic [15:0] write_staging_word_q, old_word_q;
  logic [15:0] driver_q, power_q, entry_q, bitop_q, display_q, mask_q;
  logic [10:0] pixel_memory_pointer_q;
  logic [15:0] pixel_memory [2048];
  logic do_index, do_write, do_read, step_down;

  assign pop_ready = (seq_q == LCDHP_SEQ_IDLE);
  assign do_index = pop_valid && pop_ready && pop_acc.kind == lcdhp_pkg::LCDHP_ACC_INDEX;
  assign do_write = pop_valid && pop_ready && pop_acc.kind == lcdhp_pkg::LCDHP_ACC_WRITE;
  assign do_read = pop_valid && pop_ready && pop_acc.kind == lcdhp_pkg::LCDHP_ACC_READ;
  assign step_down = entry_q[lcdhp_pkg::ENT_STEP_DOWN_BIT];

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      seq_q <= LCDHP_SEQ_IDLE;
    end else begin
      unique case (seq_q)
        LCDHP_SEQ_IDLE:
          if (do_write && index_select_q == lcdhp_pkg::IDX_PIXEL_DATA) begin
            seq_q <= LCDHP_SEQ_MERGE;
          end
        LCDHP_SEQ_MERGE: seq_q <= LCDHP_SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      index_select_q <= lcdhp_pkg::RST_INDEX;
      write_staging_word_q <= lcdhp_pkg::RST_WORD;
    end else begin
      if (do_index && pop_acc.data[4:0] <= lcdhp_pkg::IDX_MAX) begin
        index_select_q <= pop_acc.data[4:0];
      end
      if (do_write) begin
        write_staging_word_q <= pop_acc.data;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      driver_q <= lcdhp_pkg::RST_DRIVER_OUT;
      power_q <= lcdhp_pkg::RST_POWER;
      entry_q <= lcdhp_pkg::RST_ENTRY;
      bitop_q <= lcdhp_pkg::RST_BITOP;
      display_q <= lcdhp_pkg::RST_DISPLAY;
      mask_q <= lcdhp_pkg::RST_WRITE_MASK;
    end else if (do_write) begin
      unique case (index_select_q)
        lcdhp_pkg::IDX_OSC_START: power_q[lcdhp_pkg::PWR_STANDBY_BIT] <= 1'b0;
        lcdhp_pkg::IDX_DRIVER_OUT: driver_q <= pop_acc.data;
        lcdhp_pkg::IDX_POWER: power_q <= pop_acc.data;
        lcdhp_pkg::IDX_ENTRY: entry_q <= pop_acc.data;
        lcdhp_pkg::IDX_BITOP: bitop_q <= pop_acc.data;
        lcdhp_pkg::IDX_DISPLAY: display_q <= pop_acc.data;
        lcdhp_pkg::IDX_WRITE_MASK: mask_q <= pop_acc.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pixel_memory_pointer_q <= lcdhp_pkg::RST_POINTER;
    end else if (do_write && index_select_q == lcdhp_pkg::IDX_ADDR_SET) begin
      pixel_memory_pointer_q <= pop_acc.data[10:0];
    end else if (seq_q == LCDHP_SEQ_MERGE) begin
      pixel_memory_pointer_q <= step_down ? pixel_memory_pointer_q - 11'h001
                                          : pixel_memory_pointer_q + 11'h001;
    end else if (do_read && entry_q[lcdhp_pkg::ENT_READ_ADVANCE_BIT]) begin
      pixel_memory_pointer_q <= step_down ? pixel_memory_pointer_q - 11'h001
                                          : pixel_memory_pointer_q + 11'h001;
    end
  end

  // read hands back the previous staging word, then refills it: the first is a dummy
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      read_staging_word_q <= lcdhp_pkg::RST_WORD;
      old_word_q <= lcdhp_pkg::RST_WORD;
    end else begin
      if (do_read) begin
        read_staging_word_q <= pixel_memory[pixel_memory_pointer_q];
      end
      if (do_write && index_select_q == lcdhp_pkg::IDX_PIXEL_DATA) begin
        old_word_q <= pixel_memory[pixel_memory_pointer_q];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (seq_q == LCDHP_SEQ_MERGE) begin
      pixel_memory[pixel_memory_pointer_q] <= merge_word(write_staging_word_q,
        bitop_q[lcdhp_pkg::BOP_ROT_LSB +: 4], bitop_q[lcdhp_pkg::BOP_OP_LSB +: 2],
        read_staging_word_q, old_word_q, mask_q);
    end
  end

  // ==========================================================
  // display refresh on its own read port
  logic [CW-1:0] line_cnt_q;
  logic [6:0] row_q;
  logic [2:0] frame_q;
  logic [15:0] disp_word_q;
  logic [127:0] line_q, col_out_q, row_out_q;
  logic blank_q, halted, blank;
  logic [6:0] last_row;
  logic [3:0] place_word;

  assign halted = power_q[lcdhp_pkg::PWR_STANDBY_BIT];
  assign blank = halted || power_q[lcdhp_pkg::PWR_SLEEP_BIT]
              || !display_q[lcdhp_pkg::DSP_ON_BIT];
  assign last_row = {driver_q[lcdhp_pkg::DRV_LINES_LSB +: 4], 3'b111};
  assign place_word = 4'(line_cnt_q - CW'(1));

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      line_cnt_q <= '0;
      row_q <= 7'h00;
      frame_q <= 3'h0;
    end else if (!halted) begin
      if (line_cnt_q == CW'(LINE_CYCLES - 1)) begin
        line_cnt_q <= '0;
        if (row_q >= last_row) begin
          row_q <= 7'h00;
          frame_q <= (frame_q == lcdhp_pkg::FRC_FRAMES - 3'h1) ? 3'h0 : frame_q + 3'h1;
        end else begin
          row_q <= row_q + 7'h01;
        end
      end else begin
        line_cnt_q <= line_cnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    disp_word_q <= pixel_memory[{row_q, line_cnt_q[3:0]}];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      line_q <= '0;
    end else if (line_cnt_q >= CW'(1) && line_cnt_q <= CW'(lcdhp_pkg::WORDS_PER_ROW)) begin
      for (int k = 0; k < 8; k++) begin
        line_q[column_of(place_word, 3'(k), driver_q[lcdhp_pkg::DRV_COL_ORDER_BIT])] <=
          pixel_on(disp_word_q[2*k +: 2], frame_q,
                   entry_q[lcdhp_pkg::ENT_MID_GRAY_BIT]);
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      col_out_q <= '0;
      row_out_q <= '0;
      blank_q <= 1'b1;
    end else begin
      blank_q <= blank;
      if (blank) begin
        col_out_q <= '0;
        row_out_q <= '0;
      end else if (line_cnt_q == CW'(lcdhp_pkg::WORDS_PER_ROW + 1)) begin
        col_out_q <= line_q;
        row_out_q <= 128'h1 << (driver_q[lcdhp_pkg::DRV_ROW_ORDER_BIT] ? ~row_q : row_q);
      end
    end
  end

  assign o_host_data_bus = host_data_q;
  assign o_host_data_oe_n = host_oe_n_q;
  assign o_host_wait = host_wait_q;
  assign o_row_drive_outputs = row_out_q;
  assign o_column_drive_outputs = col_out_q;
  assign o_drive_blank = blank_q;
endmodule // lcdhp_host_port
`default_nettype wire

/* File: tb/lcdhp_monitor.sv */
// lcdhp_monitor: port assertions for the host port block.
// assumes: bound to lcdhp_host_port; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module lcdhp_monitor (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [2:0] i_interface_mode_pins,
  input wire logic i_chip_select_n,
  input wire logic i_command_data_select,
  input wire logic i_read_strobe_dir,
  input wire logic [15:0] o_host_data_bus,
  input wire logic o_host_data_oe_n,
  input wire logic o_host_wait,
  input wire logic [127:0] o_row_drive_outputs,
  input wire logic [127:0] o_column_drive_outputs,
  input wire logic o_drive_blank
);
  // ==========================================================
  // assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  sequence s_bus_idle;
    o_host_data_oe_n [*2];
  endsequence
  sequence s_drive_held;
    !o_host_data_oe_n [*4];
  endsequence
  a_reset_outputs: assert property ($fell(i_reset) |-> o_drive_blank && o_host_data_oe_n
    && !o_host_wait) else $error("outputs not idle after reset");
  a_blank_quiet: assert property (o_drive_blank |-> o_row_drive_outputs == 128'h0
    && o_column_drive_outputs == 128'h0) else $error("drivers active while blank");
  a_row_onehot: assert property (!o_drive_blank |-> $onehot0(o_row_drive_outputs))
    else $error("more than one row selected");
  a_read_decoded: assert property ($fell(o_host_data_oe_n) |-> $past(i_command_data_select, 3)
    && !$past(i_chip_select_n, 3)) else $error("bus driven on a disabled access");
  a_read_strobe: assert property ($fell(o_host_data_oe_n)
    && i_interface_mode_pins == lcdhp_pkg::MODE_80_16 |-> !$past(i_read_strobe_dir, 2))
    else $error("bus driven without read strobe");
  a_drive_stands: assert property ($fell(o_host_data_oe_n) |-> s_drive_held)
    else $error("read drive released early");
  a_data_holds: assert property (s_bus_idle |-> $stable(o_host_data_bus))
    else $error("read data changed between reads");
  a_wait_drains: assert property (o_host_wait |-> ##[1:32] !o_host_wait)
    else $error("wait held too long");
endmodule // lcdhp_monitor
bind lcdhp_host_port lcdhp_monitor lcdhp_monitor_i (.i_core_clk(i_core_clk), .i_reset(i_reset),
  .i_interface_mode_pins(i_interface_mode_pins), .i_chip_select_n(i_chip_select_n),
  .i_command_data_select(i_command_data_select), .i_read_strobe_dir(i_read_strobe_dir),
  .o_host_data_bus(o_host_data_bus), .o_host_data_oe_n(o_host_data_oe_n),
  .o_host_wait(o_host_wait), .o_row_drive_outputs(o_row_drive_outputs),
  .o_column_drive_outputs(o_column_drive_outputs), .o_drive_blank(o_drive_blank));
`default_nettype wire

/* File: tb/lcdhp_host_model.sv */
// lcdhp_host_model: 80-style 16-bit host processor driving the bus pins.
// assumes: design filters pins; strobe levels kept 8 core cycles.
`timescale 1ns/1ps
`default_nettype none
module lcdhp_host_model (
  input wire logic i_core_clk,
  input wire logic [15:0] i_host_data_bus,
  input wire logic i_host_data_oe_n,
  output logic [2:0] o_interface_mode_pins,
  output logic o_chip_select_n,
  output logic o_command_data_select,
  output logic o_write_strobe_n,
  output logic o_read_strobe_n,
  output logic [15:0] o_host_data_bus
);
  // ==========================================================
  // pin access
  initial begin
    o_interface_mode_pins = lcdhp_pkg::MODE_80_16;
    o_chip_select_n = 1'b1;
    o_command_data_select = 1'b0;
    o_write_strobe_n = 1'b1;
    o_read_strobe_n = 1'b1;
    o_host_data_bus = 16'h0000;
  end
  task automatic access(input logic sel, input logic rd, input logic [15:0] wdata,
                        output logic [15:0] rdata, output logic oe_n);
    @(posedge i_core_clk);
    #1;
    o_chip_select_n = 1'b0;
    o_command_data_select = sel;
    o_host_data_bus = rd ? ~o_host_data_bus : wdata;
    repeat (6) @(posedge i_core_clk);
    #1;
    if (rd) o_read_strobe_n = 1'b0;
    else o_write_strobe_n = 1'b0;
    repeat (8) @(posedge i_core_clk);
    #1;
    rdata = i_host_data_bus;
    oe_n = i_host_data_oe_n;
    o_read_strobe_n = 1'b1;
    o_write_strobe_n = 1'b1;
    repeat (8) @(posedge i_core_clk);
    #1;
    o_chip_select_n = 1'b1;
    o_host_data_bus = ~o_host_data_bus;
  endtask
endmodule // lcdhp_host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// tb_top: register-level tests of the host port through the host model.
// assumes: 50 MHz core clock, short display line parameter.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, cs_n, sel, wr_n, rd_n, oe_n, hwait, blank, oe_seen;
  logic [2:0] mode;
  logic [15:0] h2d, d2h, rdat;
  logic [127:0] rows, cols;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  lcdhp_host_port #(.FIFO_DEPTH(16), .LINE_CYCLES(20)) lcdhp_host_port_i (.i_core_clk(clk),
    .i_reset(rst), .i_interface_mode_pins(mode), .i_chip_select_n(cs_n),
    .i_command_data_select(sel), .i_write_strobe_clk(wr_n), .i_read_strobe_dir(rd_n),
    .i_host_data_bus(h2d), .o_host_data_bus(d2h), .o_host_data_oe_n(oe_n),
    .o_host_wait(hwait), .o_row_drive_outputs(rows), .o_column_drive_outputs(cols),
    .o_drive_blank(blank));
  lcdhp_host_model lcdhp_host_model_i (.i_core_clk(clk), .i_host_data_bus(d2h),
    .i_host_data_oe_n(oe_n), .o_interface_mode_pins(mode), .o_chip_select_n(cs_n),
    .o_command_data_select(sel), .o_write_strobe_n(wr_n), .o_read_strobe_n(rd_n),
    .o_host_data_bus(h2d));
  // ==========================================================
  // tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic s, input logic r, input logic [15:0] d);
    lcdhp_host_model_i.access(s, r, d, rdat, oe_seen);
  endtask
  task automatic wr(input logic [4:0] idx, input logic [15:0] val);
    acc(1'b0, 1'b0, {11'h000, idx});
    acc(1'b1, 1'b0, val);
  endtask
  task automatic rd(input logic [15:0] exp);
    acc(1'b1, 1'b1, 16'h0000);
    chk(rdat, exp);
  endtask
  task automatic rd_setup(input logic [15:0] addr);
    wr(lcdhp_pkg::IDX_ADDR_SET, addr);
    acc(1'b0, 1'b0, {11'h000, lcdhp_pkg::IDX_PIXEL_DATA});
    acc(1'b1, 1'b1, 16'h0000);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // ==========================================================
  // tests
  initial begin
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk({15'h0000, blank}, 16'h0001);
    chk({15'h0000, oe_n}, 16'h0001);
    $display("test reset done");
    wr(lcdhp_pkg::IDX_ADDR_SET, 16'h0005);
    wr(lcdhp_pkg::IDX_PIXEL_DATA, 16'hA5A5);
    wr(lcdhp_pkg::IDX_PIXEL_DATA, 16'h1234);
    rd_setup(16'h0005);
    rd(16'hA5A5);
    rd(16'hA5A5);
    wr(lcdhp_pkg::IDX_ENTRY, 16'h0002);
    rd_setup(16'h0005);
    rd(16'hA5A5);
    rd(16'h1234);
    $display("test pointer done");
    wr(lcdhp_pkg::IDX_WRITE_MASK, 16'hFF00);
    wr(lcdhp_pkg::IDX_ADDR_SET, 16'h0005);
    wr(lcdhp_pkg::IDX_PIXEL_DATA, 16'h0000);
    wr(lcdhp_pkg::IDX_WRITE_MASK, 16'h0000);
    wr(lcdhp_pkg::IDX_BITOP, 16'h0004);
    wr(lcdhp_pkg::IDX_ADDR_SET, 16'h0007);
    wr(lcdhp_pkg::IDX_PIXEL_DATA, 16'h1234);
    rd_setup(16'h0005);
    rd(16'hA500);
    rd(16'h1234);
    rd(16'h2341);
    wr(lcdhp_pkg::IDX_BITOP, 16'h0030);
    rd_setup(16'h0005);
    wr(lcdhp_pkg::IDX_PIXEL_DATA, 16'h00FF);
    rd_setup(16'h0006);
    rd(16'hA5FF);
    $display("test bit ops done");
    acc(1'b0, 1'b1, 16'h0000);
    chk({15'h0000, oe_seen}, 16'h0001);
    wr(lcdhp_pkg::IDX_DISPLAY, 16'h0001);
    repeat (60) @(posedge clk);
    #1;
    chk({15'h0000, blank}, 16'h0000);
    chk({15'h0000, $onehot(rows)}, 16'h0001);
    wr(lcdhp_pkg::IDX_POWER, 16'h0001);
    repeat (60) @(posedge clk);
    #1;
    chk({15'h0000, blank}, 16'h0001);
    chk({15'h0000, |{rows, cols}}, 16'h0000);
    chk({15'h0000, hwait}, 16'h0000);
    $display("test display done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
